// *** core/ccs_pkg.sv ***
package ccs_pkg;
    // Machine cycle position counter, one step per degree
    localparam int CCS_DEG_W = 9;
    localparam logic [8:0] CCS_DEG_LAST = 9'h167;
    localparam logic [8:0] CCS_DEG_RESET = 9'h000;
    // Stop key window on overflow indicate cycles
    localparam logic [8:0] CCS_STOP_WIN_LO = 9'h012;
    localparam logic [8:0] CCS_STOP_WIN_HI = 9'h02d;
    // Card row encodings presented on row_code
    localparam int CCS_ROW_W = 4;
    localparam logic [3:0] CCS_ROW_ZERO = 4'h0;
    localparam logic [3:0] CCS_ROW_NINE = 4'h9;
    localparam logic [3:0] CCS_ROW_ONE = 4'h1;
    localparam logic [3:0] CCS_ROW_ELEVEN = 4'hb;
    localparam logic [3:0] CCS_ROW_TWELVE = 4'hc;
    localparam logic [3:0] CCS_ROW_NONE = 4'hf;
    // Negative counter groups of counters 1 to 32
    localparam int CCS_NEG_GROUPS = 2;
    localparam logic [1:0] CCS_RUNIN_CYCLES = 2'h2;
    typedef enum logic [1:0] {
        CCS_HEAD_IDLE = 2'b00,
        CCS_HEAD_PASS = 2'b01,
        CCS_HEAD_LAST = 2'b10
    } ccs_head_t;
endpackage : ccs_pkg

// *** core/ccs_latch.sv ***
`timescale 1ns/1ps
module ccs_latch
    import ccs_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic pick,
    input wire logic release_stb,
    output logic hold_q
);
    // Pick wins over release so an impulse at cycle end is kept
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hold_q <= 1'b0;
        end else if (pick) begin
            hold_q <= 1'b1;
        end else if (release_stb) begin
            hold_q <= 1'b0;
        end
    end
endmodule : ccs_latch

// *** core/ccs_seq.sv ***
`timescale 1ns/1ps
// Function
// RULE_01: Heading-read latch sets on X or digit impulse, holds, feeds first heading latch.
// RULE_02: First heading latch inhibits the card-cycle signal.
// RULE_03: Without list wiring, first heading latch forces list for heading cards.
// RULE_04: First heading latch blocks both overflow signals when next card heads.
// RULE_05: Second heading latch sets only on the last heading card cycle.
// RULE_06: Second latch lists first body card, emits first-card impulse, blocks double space.
// RULE_07: Skip to channel 2 after last heading card, or first card when inverted.
// RULE_08: Third heading latch set while heading cards list; it blocks program start.
// RULE_09: Feed clutch latch holds and drives feed and print clutches.
// RULE_10: Idle cycle only when both clutch latches are clear.
// RULE_11: Transfer print selectors and credit symbol pass only on feed cycles.
// RULE_12: Print clutch latch drives print clutch; indicate hubs pulse on print cycles.
// RULE_13: Stop key at 18 to 45 degrees on overflow indicate prevents type lock.
// RULE_14: Speed change for first two run-in cycles and last card past third station; the run-in term here also needs the print clutch latch.
// RULE_15: List latch sets on early impulse, lists, enables lower first-card print.
// RULE_16: Non-print latch breaks print drive, listing, spacing, overflow brush; forces speed.
// RULE_17: Final total latch sets on keys with empty feed; forces print and test.
// RULE_18: Auxiliary idle blocks selector pickup and internal exit suppression picks.
// RULE_19: Zero-time gate active rows 9 to 1, 11, 12; opens compare at zero.
// RULE_20: Eleven-twelve filter passes plugboard impulses only at rows 11 and 12.
// RULE_21: Summary punch latch sets on impulse, drives punch relay, balance test if double.
// RULE_22: Conversion switches negative groups to emitter common, counters 1 to 32.
// RULE_23: Latches are flip-flops set by pick, cleared by end-of-cycle strobe.
module ccs_seq
    import ccs_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic cycle_step,
    input wire logic [3:0] row_code,
    input wire logic early_all_cycles,
    input wire logic heading_x_imp,
    input wire logic heading_digit_imp,
    input wire logic heading_next_card,
    input wire logic list_ctrl_wired,
    input wire logic list_ctrl_imp,
    input wire logic nonprint_imp,
    input wire logic feed_clutch_pick,
    input wire logic print_clutch_pick,
    input wire logic inverted_form,
    input wire logic program_running,
    input wire logic program_start_req,
    input wire logic overflow_ind_req,
    input wire logic overflow_nonind_req,
    input wire logic overflow_brush_req,
    input wire logic double_space_req,
    input wire logic minor_control_change,
    input wire logic stop_key,
    input wire logic final_total_key,
    input wire logic start_key,
    input wire logic hopper_feed_empty,
    input wire logic run_in,
    input wire logic last_card_past_third,
    input wire logic idle_cause_aux,
    input wire logic credit_symbol_imp,
    input wire logic indicate_imp,
    input wire logic plugboard_imp,
    input wire logic summary_punch_imp,
    input wire logic double_balance,
    input wire logic conversion_cycle,
    input wire logic [1:0] group_negative,
    output logic heading_read_latch,
    output logic heading_ctrl_first,
    output logic heading_ctrl_second,
    output logic heading_ctrl_third,
    output logic feed_clutch_ctrl,
    output logic print_clutch_ctrl,
    output logic feed_clutch_drive,
    output logic print_clutch_drive,
    output logic idle_cycle_signal,
    output logic idle_cycle_aux,
    output logic card_cycle_signal,
    output logic list_output,
    output logic list_ctrl_latch,
    output logic nonprint_latch,
    output logic final_total_latch,
    output logic final_total_hubs,
    output logic overflow_indicate_sig,
    output logic overflow_nonindicate_sig,
    output logic overflow_brush_ctrl,
    output logic double_space_request,
    output logic minor_first_card_imp,
    output logic lower_first_print,
    output logic skip_to_channel2,
    output logic program_start_latch,
    output logic type_bar_lock_block,
    output logic speed_change_output,
    output logic spacing_suppress,
    output logic transfer_print_entry_sel,
    output logic credit_symbol_out,
    output logic indicate_cycle_hubs,
    output logic negative_balance_test,
    output logic selector_pick_en,
    output logic exit_supp_pick_en,
    output logic zero_time_gate,
    output logic eleven_twelve_filter,
    output logic filtered_imp,
    output logic summary_punch_ctrl_latch,
    output logic summary_punch_relay,
    output logic punch_balance_test,
    output logic [1:0] correction_selector
);
    logic rst_s1_q;
    logic rst_s2_q;
    logic rst_n;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    // Machine cycle position, one count per degree step
    logic [8:0] deg_q;
    logic [8:0] deg_d;
    wire cycle_end = cycle_step && (deg_q == CCS_DEG_LAST);
    assign deg_d = cycle_end ? CCS_DEG_RESET : 9'(deg_q + 9'h001);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            deg_q <= CCS_DEG_RESET;
        end else if (cycle_step) begin
            deg_q <= deg_d;
        end
    end

    // Self-holding latches
    logic hr_q, h1_q, h2_q, h3_q, fc_q, pc_q, lc_q, np_q, ft_q, sp_q;
    wire ft_pick = final_total_key && start_key && hopper_feed_empty; // [RULE_17]
    // Heading read seen this cycle but next card is body: last heading card
    wire last_head = h1_q && hr_q && h3_q && !heading_next_card; // [RULE_05]
    wire [9:0] picks = {
        heading_x_imp || heading_digit_imp, // [RULE_01]
        hr_q, // [RULE_01]
        last_head, // [RULE_05]
        h1_q && list_output, // [RULE_08]
        feed_clutch_pick, // [RULE_09]
        print_clutch_pick || ft_q, // [RULE_17]
        list_ctrl_imp && early_all_cycles, // [RULE_15]
        nonprint_imp && early_all_cycles, // [RULE_16]
        ft_pick,
        summary_punch_imp // [RULE_21]
    };
    logic [9:0] holds;
    genvar gi;
    generate
        for (gi = 0; gi < 10; gi++) begin : g_latch
            ccs_latch u_latch ( // [RULE_23]
                .clock(clock),
                .rst_n(rst_n),
                .pick(picks[gi]),
                .release_stb(cycle_end),
                .hold_q(holds[gi])
            );
        end
    endgenerate
    assign {hr_q, h1_q, h2_q, h3_q, fc_q, pc_q, lc_q, np_q, ft_q, sp_q} = holds;

    // Run-in cycle counter for speed change
    logic [1:0] runin_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            runin_q <= 2'h0;
        end else if (!run_in) begin
            runin_q <= 2'h0;
        end else if (cycle_end && runin_q != CCS_RUNIN_CYCLES) begin
            runin_q <= 2'(runin_q + 2'h1);
        end
    end

    wire idle_w = !fc_q && !pc_q; // [RULE_10]
    wire feed_w = fc_q;
    wire print_w = (fc_q || pc_q) && !np_q; // [RULE_12] [RULE_16]
    wire list_w = !np_q && (lc_q || (h1_q && !list_ctrl_wired) || h2_q); // [RULE_03] [RULE_06]
    wire skip_w = inverted_form ? (h1_q && !h2_q && !(h3_q && program_running))
                                : h2_q; // [RULE_07]
    wire stop_win = (deg_q >= CCS_STOP_WIN_LO) && (deg_q <= CCS_STOP_WIN_HI);
    wire zero_w = (row_code >= CCS_ROW_ONE && row_code <= CCS_ROW_NINE)
                  || row_code == CCS_ROW_ELEVEN || row_code == CCS_ROW_TWELVE; // [RULE_19]
    wire et_w = row_code == CCS_ROW_ELEVEN || row_code == CCS_ROW_TWELVE; // [RULE_20]
    wire speed_w = (run_in && runin_q != CCS_RUNIN_CYCLES && pc_q)
                   || last_card_past_third || np_q || idle_w; // [RULE_14] [RULE_16]
    wire aux_w = idle_w && idle_cause_aux; // [RULE_18]

    // All outputs registered; one cycle behind their causes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            heading_read_latch <= 1'b0;
            heading_ctrl_first <= 1'b0;
            heading_ctrl_second <= 1'b0;
            heading_ctrl_third <= 1'b0;
            feed_clutch_ctrl <= 1'b0;
            print_clutch_ctrl <= 1'b0;
            feed_clutch_drive <= 1'b0;
            print_clutch_drive <= 1'b0;
            idle_cycle_signal <= 1'b0;
            idle_cycle_aux <= 1'b0;
            card_cycle_signal <= 1'b0;
            list_output <= 1'b0;
            list_ctrl_latch <= 1'b0;
            nonprint_latch <= 1'b0;
            final_total_latch <= 1'b0;
            final_total_hubs <= 1'b0;
            overflow_indicate_sig <= 1'b0;
            overflow_nonindicate_sig <= 1'b0;
            overflow_brush_ctrl <= 1'b0;
            double_space_request <= 1'b0;
            minor_first_card_imp <= 1'b0;
            lower_first_print <= 1'b0;
            skip_to_channel2 <= 1'b0;
            program_start_latch <= 1'b0;
            type_bar_lock_block <= 1'b0;
            speed_change_output <= 1'b0;
            spacing_suppress <= 1'b0;
            transfer_print_entry_sel <= 1'b0;
            credit_symbol_out <= 1'b0;
            indicate_cycle_hubs <= 1'b0;
            negative_balance_test <= 1'b0;
            selector_pick_en <= 1'b0;
            exit_supp_pick_en <= 1'b0;
            zero_time_gate <= 1'b0;
            eleven_twelve_filter <= 1'b0;
            filtered_imp <= 1'b0;
            summary_punch_ctrl_latch <= 1'b0;
            summary_punch_relay <= 1'b0;
            punch_balance_test <= 1'b0;
            correction_selector <= 2'h0;
        end else begin
            heading_read_latch <= hr_q;
            heading_ctrl_first <= h1_q;
            heading_ctrl_second <= h2_q;
            heading_ctrl_third <= h3_q;
            feed_clutch_ctrl <= fc_q;
            print_clutch_ctrl <= pc_q;
            feed_clutch_drive <= feed_w; // [RULE_09]
            print_clutch_drive <= print_w; // [RULE_09]
            idle_cycle_signal <= idle_w; // [RULE_10]
            idle_cycle_aux <= aux_w;
            card_cycle_signal <= !idle_w && !h1_q; // [RULE_02]
            list_output <= list_w;
            list_ctrl_latch <= lc_q;
            nonprint_latch <= np_q;
            final_total_latch <= ft_q;
            final_total_hubs <= ft_q; // [RULE_17]
            overflow_indicate_sig <= overflow_ind_req && !(h1_q && heading_next_card); // [RULE_04]
            overflow_nonindicate_sig <= overflow_nonind_req
                                        && !(h1_q && heading_next_card); // [RULE_04]
            overflow_brush_ctrl <= overflow_brush_req && !np_q; // [RULE_16]
            double_space_request <= double_space_req && !(h2_q && minor_control_change)
                                    && (lc_q || !minor_control_change); // [RULE_06] [RULE_15]
            minor_first_card_imp <= minor_control_change && !(h1_q && !h2_q); // [RULE_06]
            lower_first_print <= lc_q && minor_control_change; // [RULE_15]
            skip_to_channel2 <= skip_w;
            program_start_latch <= program_start_req && !h3_q; // [RULE_08]
            type_bar_lock_block <= pc_q && overflow_ind_req && stop_key && stop_win; // [RULE_13]
            speed_change_output <= speed_w;
            spacing_suppress <= np_q; // [RULE_16]
            transfer_print_entry_sel <= feed_w; // [RULE_11]
            credit_symbol_out <= credit_symbol_imp && feed_w; // [RULE_11]
            indicate_cycle_hubs <= indicate_imp && print_w; // [RULE_12]
            negative_balance_test <= ft_q; // [RULE_17]
            selector_pick_en <= !aux_w; // [RULE_18]
            exit_supp_pick_en <= !aux_w; // [RULE_18]
            zero_time_gate <= zero_w;
            eleven_twelve_filter <= et_w;
            filtered_imp <= plugboard_imp && et_w; // [RULE_20]
            summary_punch_ctrl_latch <= sp_q;
            summary_punch_relay <= sp_q; // [RULE_21]
            punch_balance_test <= sp_q && double_balance; // [RULE_21]
            correction_selector <= conversion_cycle ? group_negative : 2'h0; // [RULE_22]
        end
    end

    chk_idle_both_clear: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_10]
        idle_cycle_signal |-> !$past(fc_q) && !$past(pc_q))
        else $error("idle with a clutch latch set");
    chk_card_cycle_inhibit: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_02]
        h1_q |=> !card_cycle_signal)
        else $error("card cycle during heading");
    chk_filter_rows: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_20]
        filtered_imp |-> $past(row_code) == CCS_ROW_ELEVEN || $past(row_code) == CCS_ROW_TWELVE)
        else $error("filter passed wrong row");
    chk_zero_gate_row: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_19]
        row_code == CCS_ROW_ZERO |=> !zero_time_gate)
        else $error("zero gate at zero row");
    chk_program_block: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_08]
        h3_q |=> !program_start_latch)
        else $error("program started during heading");
    chk_overflow_block: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_04]
        h1_q && heading_next_card |=> !overflow_indicate_sig && !overflow_nonindicate_sig)
        else $error("overflow during heading");
    chk_nonprint_drive: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_16]
        np_q |=> !print_clutch_drive && !list_output && speed_change_output)
        else $error("print driven under non-print");
    chk_feed_credit: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_11]
        credit_symbol_out |-> $past(fc_q) && transfer_print_entry_sel)
        else $error("credit symbol without feed");
    chk_latch_release: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_23]
        cycle_end && !picks[0] |=> !sp_q)
        else $error("latch held past cycle end");
endmodule : ccs_seq

// *** verif/ccs_brush_model.sv ***
`timescale 1ns/1ps
module ccs_brush_model
    import ccs_pkg::*;
(
    input wire logic clock,
    input wire logic feed,
    output logic [3:0] row_code
);
    // Rows pass the brushes 12, 11, 0, 1..9; with feed off no row is read
    logic [3:0] idx_q;
    always_ff @(negedge clock) begin
        idx_q <= (!feed || idx_q == 4'hb) ? 4'h0 : idx_q + 4'h1;
    end
    assign row_code = !feed ? CCS_ROW_NONE : (idx_q == 4'h0) ? CCS_ROW_TWELVE :
        (idx_q == 4'h1) ? CCS_ROW_ELEVEN : idx_q - 4'h2;
endmodule : ccs_brush_model

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb
    import ccs_pkg::*;
;
    logic clock = 1'h0, rst_b = 1'h0, cycle_step = 1'h0, feed = 1'h0;
    logic [3:0] row_code, r;
    logic [1:0] group_negative = 2'h0, correction_selector;
    logic early_all_cycles = 1'h0, heading_x_imp = 1'h0, heading_digit_imp = 1'h0;
    logic heading_next_card = 1'h0, list_ctrl_wired = 1'h0, list_ctrl_imp = 1'h0;
    logic nonprint_imp = 1'h0, feed_clutch_pick = 1'h0, print_clutch_pick = 1'h0;
    logic inverted_form = 1'h0, program_running = 1'h0, program_start_req = 1'h0;
    logic overflow_ind_req = 1'h0, overflow_nonind_req = 1'h0, overflow_brush_req = 1'h0;
    logic double_space_req = 1'h0, minor_control_change = 1'h0, stop_key = 1'h0;
    logic final_total_key = 1'h0, start_key = 1'h0, hopper_feed_empty = 1'h0;
    logic run_in = 1'h0, last_card_past_third = 1'h0, idle_cause_aux = 1'h0;
    logic credit_symbol_imp = 1'h0, indicate_imp = 1'h0, plugboard_imp = 1'h0;
    logic summary_punch_imp = 1'h0, double_balance = 1'h0, conversion_cycle = 1'h0;
    logic heading_read_latch, heading_ctrl_first, heading_ctrl_second, heading_ctrl_third;
    logic feed_clutch_ctrl, print_clutch_ctrl, feed_clutch_drive, print_clutch_drive;
    logic idle_cycle_signal, idle_cycle_aux, card_cycle_signal, list_output;
    logic list_ctrl_latch, nonprint_latch, final_total_latch, final_total_hubs;
    logic overflow_indicate_sig, overflow_nonindicate_sig, overflow_brush_ctrl;
    logic double_space_request, minor_first_card_imp, lower_first_print, skip_to_channel2;
    logic program_start_latch, type_bar_lock_block, speed_change_output, spacing_suppress;
    logic transfer_print_entry_sel, credit_symbol_out, indicate_cycle_hubs;
    logic negative_balance_test, selector_pick_en, exit_supp_pick_en, zero_time_gate;
    logic eleven_twelve_filter, filtered_imp, summary_punch_ctrl_latch;
    logic summary_punch_relay, punch_balance_test;
    int fail_count = 0;
    int n_tests = 0;
    string cur;
    ccs_seq uut (.*);
    ccs_brush_model brushes (.clock(clock), .feed(feed), .row_code(row_code));
    initial begin
        forever #2 clock = ~clock;
    end
    task automatic cy(input int n);
        repeat (n) @(negedge clock);
    endtask : cy
    task automatic chk(input logic g, input logic e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t in %s", $time, cur);
        end
    endtask : chk
    // Steps the degree counter; a full 360 ends the cycle and drops latches
    task automatic stp(input int n);
        cycle_step = 1'h1;
        cy(n);
        cycle_step = 1'h0;
        cy(4);
    endtask : stp
    task automatic pulse(ref logic s);
        s = 1'h1;
        cy(1);
        s = 1'h0;
    endtask : pulse
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    task automatic t_idle;
        cur = "idle";
        chk(feed_clutch_ctrl, 1'h0);
        chk(idle_cycle_signal, 1'h1);
        chk(selector_pick_en, 1'h1);
        idle_cause_aux = 1'h1;
        cy(2);
        chk(idle_cycle_aux, 1'h1);
        chk(selector_pick_en, 1'h0);
        chk(exit_supp_pick_en, 1'h0);
        idle_cause_aux = 1'h0;
    endtask : t_idle
    task automatic t_feed;
        cur = "feed";
        // Run-in speed change follows the print clutch latch, so pick both
        print_clutch_pick = 1'h1;
        pulse(feed_clutch_pick);
        print_clutch_pick = 1'h0;
        credit_symbol_imp = 1'h1;
        cy(3);
        chk(feed_clutch_drive & print_clutch_drive & feed_clutch_ctrl, 1'h1);
        chk(card_cycle_signal, 1'h1);
        chk(idle_cycle_signal, 1'h0);
        chk(transfer_print_entry_sel & credit_symbol_out, 1'h1);
        chk(speed_change_output, 1'h0);
        run_in = 1'h1;
        cy(2);
        chk(speed_change_output, 1'h1);
        run_in = 1'h0;
        last_card_past_third = 1'h1;
        cy(2);
        chk(speed_change_output, 1'h1);
        last_card_past_third = 1'h0;
        stp(360);
        chk(feed_clutch_ctrl | transfer_print_entry_sel | credit_symbol_out, 1'h0);
        chk(idle_cycle_signal, 1'h1);
        credit_symbol_imp = 1'h0;
    endtask : t_feed
    task automatic t_head;
        cur = "head";
        pulse(feed_clutch_pick);
        {heading_next_card, overflow_ind_req, overflow_nonind_req} = 3'h7;
        {program_start_req, double_space_req} = 2'h3;
        pulse(heading_x_imp);
        cy(6);
        chk(heading_read_latch & heading_ctrl_first, 1'h1);
        chk(card_cycle_signal, 1'h0);
        chk(list_output, 1'h1);
        chk(overflow_indicate_sig | overflow_nonindicate_sig, 1'h0);
        chk(heading_ctrl_third, 1'h1);
        chk(program_start_latch, 1'h0);
        chk(heading_ctrl_second | skip_to_channel2, 1'h0);
        heading_next_card = 1'h0;
        // Minor change with list latch set: only the second latch drops double space
        {minor_control_change, early_all_cycles} = 2'h3;
        pulse(list_ctrl_imp);
        early_all_cycles = 1'h0;
        cy(4);
        chk(heading_ctrl_second, 1'h1);
        chk(skip_to_channel2, 1'h1);
        chk(double_space_request, 1'h0);
        chk(minor_first_card_imp, 1'h1);
        chk(overflow_indicate_sig & overflow_nonindicate_sig, 1'h1);
        chk(list_output, 1'h1);
        // Latches feeding one another take one cycle end each to drain
        stp(1080);
        chk(heading_read_latch | heading_ctrl_first | heading_ctrl_second, 1'h0);
        chk(program_start_latch, 1'h1);
        {program_start_req, double_space_req, overflow_ind_req, overflow_nonind_req} = 4'h0;
        minor_control_change = 1'h0;
        stp(360);
        {inverted_form, program_running, heading_next_card} = 3'h7;
        pulse(heading_digit_imp);
        cy(6);
        chk(heading_ctrl_first, 1'h1);
        chk(skip_to_channel2, 1'h0);
        program_running = 1'h0;
        cy(2);
        chk(skip_to_channel2, 1'h1);
        stp(1080);
        {inverted_form, heading_next_card} = 2'h0;
    endtask : t_head
    task automatic t_stop;
        cur = "stop";
        {overflow_ind_req, stop_key, indicate_imp} = 3'h7;
        pulse(print_clutch_pick);
        stp(17);
        chk(print_clutch_drive & indicate_cycle_hubs, 1'h1);
        chk(type_bar_lock_block, 1'h0);
        stp(1);
        chk(type_bar_lock_block, 1'h1);
        stp(27);
        chk(type_bar_lock_block, 1'h1);
        stp(1);
        chk(type_bar_lock_block, 1'h0);
        stp(314);
        chk(print_clutch_ctrl | indicate_cycle_hubs, 1'h0);
        {overflow_ind_req, stop_key, indicate_imp} = 3'h0;
    endtask : t_stop
    task automatic t_list;
        cur = "list";
        {list_ctrl_wired, minor_control_change, overflow_brush_req} = 3'h7;
        pulse(feed_clutch_pick);
        early_all_cycles = 1'h1;
        pulse(list_ctrl_imp);
        cy(3);
        chk(list_ctrl_latch & list_output & lower_first_print, 1'h1);
        chk(overflow_brush_ctrl, 1'h1);
        pulse(nonprint_imp);
        early_all_cycles = 1'h0;
        cy(3);
        chk(nonprint_latch & spacing_suppress & speed_change_output, 1'h1);
        chk(print_clutch_drive | list_output | overflow_brush_ctrl, 1'h0);
        stp(360);
        chk(nonprint_latch | list_ctrl_latch, 1'h0);
        {list_ctrl_wired, minor_control_change, overflow_brush_req} = 3'h0;
    endtask : t_list
    task automatic t_final;
        cur = "final";
        {final_total_key, start_key} = 2'h3;
        cy(4);
        chk(final_total_latch, 1'h0);
        hopper_feed_empty = 1'h1;
        cy(4);
        chk(final_total_latch & final_total_hubs, 1'h1);
        chk(print_clutch_ctrl & negative_balance_test, 1'h1);
        {final_total_key, start_key, hopper_feed_empty} = 3'h0;
        stp(720);
    endtask : t_final
    task automatic t_misc;
        cur = "misc";
        double_balance = 1'h1;
        pulse(summary_punch_imp);
        cy(3);
        chk(summary_punch_ctrl_latch & summary_punch_relay & punch_balance_test, 1'h1);
        {conversion_cycle, group_negative} = 3'h6;
        cy(2);
        chk(correction_selector == 2'h2, 1'h1);
        conversion_cycle = 1'h0;
        cy(2);
        chk(correction_selector == 2'h0, 1'h1);
        stp(360);
        chk(summary_punch_ctrl_latch, 1'h0);
        double_balance = 1'h0;
    endtask : t_misc
    task automatic t_rows;
        cur = "rows";
        {feed, plugboard_imp} = 2'h3;
        repeat (13) begin
            // Row moves at the falling edge; take it after that, judge after the rise
            @(negedge clock);
            #1;
            r = row_code;
            @(posedge clock);
            #1;
            chk(zero_time_gate, r != CCS_ROW_ZERO && r != CCS_ROW_NONE);
            chk(filtered_imp, r == CCS_ROW_ELEVEN || r == CCS_ROW_TWELVE);
            chk(eleven_twelve_filter, r == CCS_ROW_ELEVEN || r == CCS_ROW_TWELVE);
        end
        cy(1);
        {feed, plugboard_imp} = 2'h0;
    endtask : t_rows
    initial begin
        cy(6);
        rst_b = 1'h1;
        cy(5);
        t_idle();
        $display("test %s done", cur);
        t_feed();
        $display("test %s done", cur);
        t_head();
        $display("test %s done", cur);
        t_stop();
        $display("test %s done", cur);
        t_list();
        $display("test %s done", cur);
        t_final();
        $display("test %s done", cur);
        t_misc();
        $display("test %s done", cur);
        t_rows();
        $display("test %s done", cur);
        $display("all scenarios run");
        end_of_test();
    end
    initial begin
        #200000;
        fail_count++;
        end_of_test();
    end
endmodule : tb
